// file: verilog/ssc_device.sv
// Device end: serial configuration bank of the synthesizer
//
// Overview of operation
// RL1: Reference divide ratio 4 to 255 only.
// RL2: Prescaler code 00/01/1x gives 4/8/16.
// RL3: Host keeps integer within prescaler range.
// RL4: Host raises chip_wake before active_release.
// RL5: Pin pair selects down, save or normal.
// RL6: Host waits 50us after wake before writing.
// RL7: Power save floats the pump output.
// RL8: Release drop keeps programmed contents.
// RL9: Numerator pends until integer word written.
// RL10: Host writes numerator then integer word.
// RL11: Contents undefined; host writes every address.
// RL12: Numerator word holds 18-bit fraction.
// RL13: Integer word holds current code, divide.
// RL14: pump_float tri-states the pump output.
// RL15: noise_spread_on enables dithering.
// RL16: Lock window 1/2/3 cycles, 11 forbidden.
// RL17: lock_detect_select picks digital or analog.
// RL18: pump_sign sets pump polarity.
// RL19: Lock after 63 good comparisons.
// RL20: Boost runs boost_count cycles after trigger.
// RL21: Host programs boost_count 1 to 8191.
// RL22: 24 bits shifted, committed on strobe.
// RL23: Unknown addresses are ignored.
`timescale 1ns/1ps
`include "ssc_consts.svh"
module ssc_device
  import ssc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  ssc_link_if.device       link,
  input  wire logic        pd_tick,
  input  wire logic        phase_ok,
  input  wire logic        analog_lock_in,
  output logic [17:0]      fraction_top,
  output logic [14:0]      whole_divide_value,
  output logic [3:0]       pump_normal_current,
  output logic [2:0]       pump_fast_current,
  output logic [7:0]       ref_divide,
  output logic [4:0]       prescaler_p,
  output logic             noise_spread_on,
  output logic [1:0]       lock_window_pick,
  output logic             lock_detect_select,
  output logic             pump_sign,
  output logic             pump_hiz,
  output logic             boost_on,
  output logic             lock_out,
  output logic             setting_bad,
  output ssc_power_t       power_state
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  localparam int NPIN = 5;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1, s2, s3, pin, pin_q;
  assign pin_raw = {link.active_release, link.chip_wake, link.load_strobe,
                    link.sclk, link.sdata};
  // Three stages; a level counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          s1[g]    <= 1'b0;
          s2[g]    <= 1'b0;
          s3[g]    <= 1'b0;
          pin[g]   <= 1'b0;
          pin_q[g] <= 1'b0;
        end else if (clk_en) begin
          s1[g] <= pin_raw[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          if (s2[g] == s3[g]) begin
            pin[g] <= s3[g];
          end
          pin_q[g] <= pin[g];
        end
      end
    end
  endgenerate
  logic sdata_i, sclk_rise, load_rise, wake_i, release_i, release_rise;
  assign sdata_i      = pin[0];
  assign sclk_rise    = pin[1] & ~pin_q[1];
  assign load_rise    = pin[2] & ~pin_q[2];
  assign wake_i       = pin[3];
  assign release_i    = pin[4];
  assign release_rise = pin[4] & ~pin_q[4];

  // ------------------------------------------------------------
  // Serial shifter and word commit
  // ------------------------------------------------------------
  logic [`SSC_WORD_BITS-1:0] shift_word;
  logic [3:0]                word_addr;
  logic [`SSC_DATA_MSB:0]    word_data;
  assign word_addr = shift_word[`SSC_ADDR_MSB:`SSC_ADDR_LSB];
  assign word_data = shift_word[`SSC_DATA_MSB:0];
  // Shift in on each serial clock rise while the chip is awake
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_word <= 24'h00_0000;
    end else if (clk_en && wake_i && sclk_rise) begin
      shift_word <= {shift_word[`SSC_WORD_BITS-2:0], sdata_i}; // [RL22]
    end
  end

  logic [17:0] num_pending;
  logic [12:0] boost_count;
  logic        commit, freq_change, boost_enable, pump_float;
  assign commit = clk_en && wake_i && load_rise; // [RL22]
  // Register bank, zero after reset except prescaler_p at 4 [RL11]; kept on release [RL8]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      num_pending         <= 18'h0_0000;
      fraction_top        <= 18'h0_0000;
      whole_divide_value  <= 15'h0000;
      pump_normal_current <= 4'h0;
      pump_float          <= 1'b0;
      noise_spread_on     <= 1'b0;
      lock_window_pick    <= 2'h0;
      lock_detect_select  <= 1'b0;
      pump_sign           <= 1'b0;
      prescaler_p         <= 5'h04;
      ref_divide          <= 8'h00;
      boost_enable        <= 1'b0;
      pump_fast_current   <= 3'h0;
      boost_count         <= 13'h0000;
      freq_change         <= 1'b0;
    end else if (clk_en) begin
      freq_change <= 1'b0;
      if (commit) begin
        unique case (word_addr)
          `SSC_ADDR_NUM: begin
            num_pending <= word_data[`SSC_NUM_MSB:0]; // [RL9] [RL12]
          end
          `SSC_ADDR_INT: begin
            fraction_top        <= num_pending; // [RL9]
            pump_normal_current <= word_data[`SSC_PNC_MSB:`SSC_PNC_LSB]; // [RL13]
            whole_divide_value  <= word_data[`SSC_WDV_MSB:0]; // [RL13]
            freq_change         <= 1'b1;
          end
          `SSC_ADDR_DIV: begin
            pump_float         <= word_data[`SSC_FLOAT_BIT]; // [RL14]
            noise_spread_on    <= word_data[`SSC_NSO_BIT]; // [RL15]
            lock_window_pick   <= word_data[`SSC_LWP_MSB:`SSC_LWP_LSB]; // [RL16]
            lock_detect_select <= word_data[`SSC_LDS_BIT]; // [RL17]
            pump_sign          <= word_data[`SSC_SIGN_BIT]; // [RL18]
            ref_divide         <= word_data[`SSC_REF_MSB:0]; // [RL1]
            // Codes 10 and 11 both give sixteen
            unique case (word_data[`SSC_PRE_MSB:`SSC_PRE_LSB])
              2'h0:    prescaler_p <= 5'h04; // [RL2]
              2'h1:    prescaler_p <= 5'h08; // [RL2]
              default: prescaler_p <= 5'h10; // [RL2]
            endcase
          end
          `SSC_ADDR_FAST: begin
            boost_enable      <= word_data[`SSC_BEN_BIT];
            pump_fast_current <= word_data[`SSC_PFC_MSB:`SSC_PFC_LSB];
            boost_count       <= word_data[`SSC_BCNT_MSB:0];
          end
          default: begin
            // Other addresses leave the bank untouched [RL23]
          end
        endcase
      end
    end
  end

  // Flags settings that the device cannot honour
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      setting_bad <= 1'b0;
    end else if (clk_en) begin
      setting_bad <= (ref_divide < `SSC_REF_MIN) ||
                     (lock_window_pick == `SSC_LWP_BAD); // [RL1] [RL16]
    end
  end

  // ------------------------------------------------------------
  // Power state and pump output control
  // ------------------------------------------------------------
  ssc_power_t next_power_state;
  always_comb begin
    unique case ({wake_i, release_i})
      2'b00:   next_power_state = SSC_PWR_DOWN; // [RL5]
      2'b10:   next_power_state = SSC_PWR_SAVE; // [RL5]
      2'b11:   next_power_state = SSC_PWR_NORMAL; // [RL5]
      default: next_power_state = SSC_PWR_BAD; // [RL5]
    endcase
  end
  // Pump floats unless running normally with float clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_state <= SSC_PWR_DOWN;
      pump_hiz    <= 1'b1;
    end else if (clk_en) begin
      power_state <= next_power_state;
      pump_hiz    <= pump_float ||
                     (next_power_state != SSC_PWR_NORMAL); // [RL7] [RL14]
    end
  end

  // ------------------------------------------------------------
  // Fast-lock boost timer, counted in phase detector cycles
  // ------------------------------------------------------------
  logic [12:0] boost_left;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boost_left <= 13'h0000;
      boost_on   <= 1'b0;
    end else if (clk_en) begin
      if (boost_enable && (freq_change || release_rise)) begin
        boost_left <= boost_count; // [RL20]
        boost_on   <= (boost_count != 13'h0000);
      end else if (pd_tick && boost_left != 13'h0000) begin
        boost_left <= boost_left - 13'h0001; // [RL20]
        boost_on   <= (boost_left != 13'h0001);
      end
    end
  end

  // ------------------------------------------------------------
  // Lock detect
  // ------------------------------------------------------------
  logic [5:0] good_run;
  logic [2:0] bad_run;
  logic       digital_lock;
  // Drops at each new frequency, rises after a run of good compares
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      good_run     <= 6'h00;
      bad_run      <= 3'h0;
      digital_lock <= 1'b0;
    end else if (clk_en) begin
      if (freq_change) begin
        good_run     <= 6'h00; // [RL19]
        bad_run      <= 3'h0;
        digital_lock <= 1'b0; // [RL19]
      end else if (pd_tick) begin
        if (phase_ok) begin
          bad_run <= 3'h0;
          if (good_run != `SSC_LOCK_RUN) begin
            good_run <= good_run + 6'h01;
          end
          if (good_run == `SSC_LOCK_RUN - 6'h01) begin
            digital_lock <= 1'b1; // [RL19]
          end
        end else begin
          good_run <= 6'h00;
          if (bad_run != `SSC_UNLOCK_RUN) begin
            bad_run <= bad_run + 3'h1;
          end
          if (bad_run == `SSC_UNLOCK_RUN - 3'h1) begin
            digital_lock <= 1'b0;
          end
        end
      end
    end
  end
  // Lock pin source selection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_out <= 1'b0;
    end else if (clk_en) begin
      lock_out <= lock_detect_select ? analog_lock_in : digital_lock; // [RL17]
    end
  end
endmodule

// file: verilog/ssc_consts.svh
// Constants of the synthesizer serial configuration bank and its host
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH
// ------------------------------------------------------------
// Serial word layout: address first, then 20 data bits, MSB first
// ------------------------------------------------------------
`define SSC_WORD_BITS    24
`define SSC_ADDR_MSB     23
`define SSC_ADDR_LSB     20
`define SSC_DATA_MSB     19
`define SSC_ADDR_NUM     4'h1
`define SSC_ADDR_INT     4'h2
`define SSC_ADDR_DIV     4'h3
`define SSC_ADDR_FAST    4'h4
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SSC_NUM_MSB      17
`define SSC_PNC_MSB      18
`define SSC_PNC_LSB      15
`define SSC_WDV_MSB      14
`define SSC_FLOAT_BIT    15
`define SSC_NSO_BIT      14
`define SSC_LWP_MSB      13
`define SSC_LWP_LSB      12
`define SSC_LDS_BIT      11
`define SSC_SIGN_BIT     10
`define SSC_PRE_MSB      9
`define SSC_PRE_LSB      8
`define SSC_REF_MSB      7
`define SSC_BEN_BIT      16
`define SSC_PFC_MSB      15
`define SSC_PFC_LSB      13
`define SSC_BCNT_MSB     12
// ------------------------------------------------------------
// Reset values and limits
// ------------------------------------------------------------
`define SSC_WORD_RST     20'h0_0000
`define SSC_REF_MIN      8'h04
`define SSC_LWP_BAD      2'h3
`define SSC_INT_MIN_P4   15'h0059
`define SSC_INT_MAX_P4   15'h1FFF
`define SSC_INT_MIN_P8   15'h00C9
`define SSC_INT_MAX_P8   15'h3FFF
`define SSC_INT_MIN_P16  15'h0209
`define SSC_INT_MAX_P16  15'h7FFF
`define SSC_LOCK_RUN     6'h3F
`define SSC_UNLOCK_RUN   3'h4
// ------------------------------------------------------------
// Host register offsets and timing
// ------------------------------------------------------------
`define SSC_REG_CTRL     8'h00
`define SSC_REG_TX       8'h04
`define SSC_REG_STAT     8'h08
`define SSC_CLK_PERIOD_NS 25
`define SSC_WAKE_SETTLE_NS 50000
`define SSC_WAKE_SETTLE_CYC ((`SSC_WAKE_SETTLE_NS + `SSC_CLK_PERIOD_NS - 1) / `SSC_CLK_PERIOD_NS)
`define SSC_SCLK_HALF_CYC 4'h4
`endif

// file: verilog/ssc_pkg.sv
// Types shared by both ends of the serial configuration link
package ssc_pkg;
  typedef enum logic [1:0] {
    SSC_PWR_DOWN,
    SSC_PWR_SAVE,
    SSC_PWR_NORMAL,
    SSC_PWR_BAD
  } ssc_power_t;
  typedef enum logic [2:0] {
    SSC_H_IDLE,
    SSC_H_BIT_LO,
    SSC_H_BIT_HI,
    SSC_H_LOAD,
    SSC_H_GAP
  } ssc_host_state_t;
endpackage

// file: verilog/ssc_link_if.sv
// Three-wire write link plus the two power pins
`timescale 1ns/1ps
interface ssc_link_if;
  logic sdata;
  logic sclk;
  logic load_strobe;
  logic chip_wake;
  logic active_release;
  modport host (
    output sdata,
    output sclk,
    output load_strobe,
    output chip_wake,
    output active_release
  );
  modport device (
    input  sdata,
    input  sclk,
    input  load_strobe,
    input  chip_wake,
    input  active_release
  );
endinterface

// file: verilog/ssc_host.sv
// Host end: AHB-Lite controlled driver of the three-wire link
`timescale 1ns/1ps
`include "ssc_consts.svh"
module ssc_host
  import ssc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  ssc_link_if.host         link
);
  // ------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ------------------------------------------------------------
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        ctrl_wake;
  logic        ctrl_release;
  logic        busy;
  logic        wake_ready;
  logic        refused;
  logic [1:0]  last_pre;
  logic        accept;
  logic        start;
  assign accept = hsel && hready && htrans[1];

  // Address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (clk_en) begin
      wr_pend <= accept && hwrite;
      wr_addr <= haddr;
      if (accept && !hwrite) begin
        unique case (haddr)
          `SSC_REG_CTRL: hrdata <= {30'h0, ctrl_release, ctrl_wake};
          `SSC_REG_STAT: hrdata <= {29'h0, refused, wake_ready, busy};
          default:       hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Word validity against the host's limits
  logic [14:0] int_v;
  logic        word_ok;
  always_comb begin
    int_v   = hwdata[`SSC_WDV_MSB:0];
    word_ok = 1'b1;
    unique case (hwdata[`SSC_ADDR_MSB:`SSC_ADDR_LSB])
      `SSC_ADDR_INT: begin
        unique case (last_pre)
          2'h0: word_ok = int_v >= `SSC_INT_MIN_P4 &&
                          int_v <= `SSC_INT_MAX_P4; // [RL3]
          2'h1: word_ok = int_v >= `SSC_INT_MIN_P8 &&
                          int_v <= `SSC_INT_MAX_P8; // [RL3]
          default: word_ok = int_v >= `SSC_INT_MIN_P16; // [RL3]
        endcase
      end
      `SSC_ADDR_DIV: word_ok =
        hwdata[`SSC_REF_MSB:0] >= `SSC_REF_MIN &&
        hwdata[`SSC_LWP_MSB:`SSC_LWP_LSB] != `SSC_LWP_BAD; // [RL1] [RL16]
      `SSC_ADDR_FAST: word_ok = hwdata[`SSC_BCNT_MSB:0] != 13'h0000; // [RL21]
      default: word_ok = 1'b1;
    endcase
  end

  assign start = wr_pend && wr_addr == `SSC_REG_TX && !busy &&
                 wake_ready && word_ok; // [RL6]

  // Control, refusal flag and remembered prescaler code
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_wake    <= 1'b0;
      ctrl_release <= 1'b0;
      refused      <= 1'b0;
      last_pre     <= 2'h0;
    end else if (clk_en && wr_pend) begin
      unique case (wr_addr)
        `SSC_REG_CTRL: begin
          ctrl_wake    <= hwdata[0];
          ctrl_release <= hwdata[1];
        end
        `SSC_REG_STAT: begin
          if (hwdata[2]) begin
            refused <= 1'b0;
          end
        end
        `SSC_REG_TX: begin
          if (start) begin
            if (hwdata[`SSC_ADDR_MSB:`SSC_ADDR_LSB] == `SSC_ADDR_DIV) begin
              last_pre <= hwdata[`SSC_PRE_MSB:`SSC_PRE_LSB];
            end
          end else begin
            refused <= 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Power pins and wake settle timer
  // ------------------------------------------------------------
  logic [11:0] wake_cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.chip_wake      <= 1'b0;
      link.active_release <= 1'b0;
      wake_cnt            <= 12'h000;
      wake_ready          <= 1'b0;
    end else if (clk_en) begin
      link.chip_wake <= ctrl_wake;
      // Release follows wake a cycle later and falls with it
      link.active_release <= ctrl_release && ctrl_wake &&
                             link.chip_wake; // [RL4] [RL5]
      if (!link.chip_wake) begin
        wake_cnt   <= 12'h000;
        wake_ready <= 1'b0;
      end else if (wake_cnt != 12'(`SSC_WAKE_SETTLE_CYC)) begin
        wake_cnt <= wake_cnt + 12'h001; // [RL6]
      end else begin
        wake_ready <= 1'b1; // [RL6]
      end
    end
  end

  // ------------------------------------------------------------
  // Serial shifter, address first, MSB first
  // ------------------------------------------------------------
  ssc_host_state_t state;
  logic [3:0]      half_cnt;
  logic [4:0]      bit_cnt;
  logic [23:0]     sh;
  logic            half_done;
  assign half_done = half_cnt == `SSC_SCLK_HALF_CYC - 4'h1;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state            <= SSC_H_IDLE;
      half_cnt         <= 4'h0;
      bit_cnt          <= 5'h00;
      sh               <= 24'h00_0000;
      busy             <= 1'b0;
      link.sdata       <= 1'b0;
      link.sclk        <= 1'b0;
      link.load_strobe <= 1'b0;
    end else if (clk_en) begin
      half_cnt <= half_done ? 4'h0 : half_cnt + 4'h1;
      unique case (state)
        SSC_H_IDLE: begin
          half_cnt <= 4'h0;
          if (start) begin
            busy       <= 1'b1;
            sh         <= {hwdata[22:0], 1'b0};
            link.sdata <= hwdata[23]; // [RL22]
            bit_cnt    <= 5'h17;
            state      <= SSC_H_BIT_LO;
          end
        end
        SSC_H_BIT_LO: if (half_done) begin
          link.sclk <= 1'b1; // [RL22]
          state     <= SSC_H_BIT_HI;
        end
        SSC_H_BIT_HI: if (half_done) begin
          link.sclk <= 1'b0;
          if (bit_cnt == 5'h00) begin
            link.load_strobe <= 1'b1; // [RL22]
            state            <= SSC_H_LOAD;
          end else begin
            link.sdata <= sh[23];
            sh         <= {sh[22:0], 1'b0};
            bit_cnt    <= bit_cnt - 5'h01;
            state      <= SSC_H_BIT_LO;
          end
        end
        SSC_H_LOAD: if (half_done) begin
          link.load_strobe <= 1'b0;
          state            <= SSC_H_GAP;
        end
        SSC_H_GAP: if (half_done) begin
          busy  <= 1'b0;
          state <= SSC_H_IDLE;
        end
      endcase
    end
  end
endmodule

// file: test/ssc_link_sva.sv
// Checker of the three-wire link between the host and device ends
`timescale 1ns/1ps
module ssc_link_sva (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sdata,
  input wire logic sclk,
  input wire logic load_strobe,
  input wire logic chip_wake,
  input wire logic active_release
);
  localparam int WAKE_CYC = 2000;
  logic [11:0] wake_cnt;
  logic [5:0]  bit_cnt;
  logic        sclk_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Cycles of chip_wake high, saturating at the settle time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_cnt <= 12'h000;
    end else if (!chip_wake) begin
      wake_cnt <= 12'h000;
    end else if (wake_cnt < 12'(WAKE_CYC)) begin
      wake_cnt <= wake_cnt + 12'h001;
    end
  end
  // Serial clock rises since the last strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_q  <= 1'b0;
      bit_cnt <= 6'h00;
    end else begin
      sclk_q <= sclk;
      if (load_strobe) begin
        bit_cnt <= 6'h00;
      end else if (sclk && !sclk_q) begin
        bit_cnt <= bit_cnt + 6'h01;
      end
    end
  end
  sequence strobe_pulse_s;
    load_strobe [*4] ##1 !load_strobe;
  endsequence
  sequence clock_high_s;
    sclk [*4] ##1 !sclk;
  endsequence
  wake_first_a: assert property (
    $rose(active_release) |-> $past(chip_wake))
    else $error("release rose without wake");
  pin_pair_a: assert property (active_release |-> chip_wake)
    else $error("release high with wake low");
  wake_settle_a: assert property (
    (sclk || load_strobe) |-> wake_cnt == 12'(WAKE_CYC))
    else $error("link active before wake settle");
  bit_count_a: assert property (
    $rose(load_strobe) |-> bit_cnt == 6'h18)
    else $error("strobe not after 24 bits");
  strobe_len_a: assert property ($rose(load_strobe) |-> strobe_pulse_s)
    else $error("strobe width wrong");
  clock_high_a: assert property ($rose(sclk) |-> clock_high_s)
    else $error("serial clock high time wrong");
  clock_low_a: assert property ($fell(sclk) |-> !sclk [*4])
    else $error("serial clock low time wrong");
  data_hold_a: assert property (sclk |-> $stable(sdata))
    else $error("data moved while clock high");
endmodule

// file: test/testbench.sv
// Testbench joining the host and device ends of the link
`timescale 1ns/1ps
module testbench
  import ssc_pkg::*;
;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        pd_tick = 1'b0;
  logic        phase_ok = 1'b1;
  logic        hready, hreadyout, hresp;
  logic [31:0] hrdata;
  logic [17:0] fraction_top;
  logic [14:0] whole_divide_value;
  logic [7:0]  ref_divide;
  logic [4:0]  prescaler_p;
  logic [3:0]  pump_normal_current;
  logic [2:0]  pump_fast_current;
  logic [1:0]  lock_window_pick;
  logic        noise_spread_on, lock_detect_select, pump_sign, pump_hiz;
  logic        boost_on, lock_out, setting_bad;
  ssc_power_t  power_state;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          cycles = 0;
  assign hready = hreadyout;
  // Clock of 25 ns period
  always #12.5 hclk = ~hclk;
  ssc_link_if i_ssc_link_if ();
  ssc_host i_ssc_host (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .link(i_ssc_link_if));
  ssc_device i_ssc_device (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
    .link(i_ssc_link_if), .pd_tick(pd_tick), .phase_ok(phase_ok),
    .analog_lock_in(phase_ok), .fraction_top(fraction_top),
    .whole_divide_value(whole_divide_value),
    .pump_normal_current(pump_normal_current),
    .pump_fast_current(pump_fast_current), .ref_divide(ref_divide),
    .prescaler_p(prescaler_p), .noise_spread_on(noise_spread_on),
    .lock_window_pick(lock_window_pick),
    .lock_detect_select(lock_detect_select), .pump_sign(pump_sign),
    .pump_hiz(pump_hiz), .boost_on(boost_on), .lock_out(lock_out),
    .setting_bad(setting_bad), .power_state(power_state));
  ssc_link_sva i_ssc_link_sva (.hclk(hclk), .hresetn(hresetn),
    .sdata(i_ssc_link_if.sdata), .sclk(i_ssc_link_if.sclk),
    .load_strobe(i_ssc_link_if.load_strobe),
    .chip_wake(i_ssc_link_if.chip_wake),
    .active_release(i_ssc_link_if.active_release));
  // -----------------------------------------------------------
  // Bus and link tasks
  // -----------------------------------------------------------
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0000_0000, x);
    chk(x, e);
  endtask
  // Send one word, wait for the host to go idle, then eight more cycles
  task automatic send(input logic [23:0] w);
    logic [31:0] s;
    wr(8'h04, {8'h00, w});
    do ahb(1'b0, 8'h08, 32'h0000_0000, s); while (s[0] !== 1'b0);
    repeat (8) @(posedge hclk);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      pd_tick <= 1'b1;
      @(posedge hclk);
      pd_tick <= 1'b0;
      @(posedge hclk);
    end
    repeat (3) @(posedge hclk);
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge hclk) begin
    cycles++;
    if (cycles >= 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // -----------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------
  initial begin
    logic [31:0] s;
    logic [19:0] d;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({pump_hiz, prescaler_p, power_state}, 8'h90);
    rdc(8'h0C, 32'h0000_0000);
    wr(8'h00, 32'h0000_0003);
    repeat (10) @(posedge hclk);
    chk(power_state, SSC_PWR_NORMAL);
    send(24'h30_0004);
    rdc(8'h08, 32'h0000_0004);
    wr(8'h08, 32'h0000_0004);
    do ahb(1'b0, 8'h08, 32'h0000_0000, s); while (s[1] !== 1'b1);
    send(24'h12_3333);
    chk(fraction_top, 18'h0_0000);
    send({4'h2, 1'b0, 4'hA, 15'h01D5});
    chk(fraction_top, 18'h2_3333);
    chk({pump_normal_current, whole_divide_value}, {4'hA, 15'h01D5});
    send(24'h30_0003);
    rdc(8'h08, 32'h0000_0006);
    wr(8'h08, 32'h0000_0004);
    send(24'hB0_0055);
    send(24'h60_0123);
    wr(8'h08, 32'h0000_0004);
    chk({setting_bad, ref_divide, whole_divide_value},
        {1'b1, 8'h00, 15'h01D5});
    for (int i = 0; i < 4; i++) begin
      d = {4'h0, ^2'(i), i[1], (i == 3) ? 2'h2 : 2'(i), i == 1, ~i[0],
           2'(i), 8'(4 + 83 * i)};
      send({4'h3, d});
      chk({pump_hiz, noise_spread_on, lock_window_pick,
           lock_detect_select, pump_sign, ref_divide, setting_bad},
          {d[15:10], d[7:0], 1'b0});
      chk(lock_out, i == 1);
      chk(prescaler_p, 5'h04 << ((i > 1) ? 2 : i));
    end
    send(24'h41_0000);
    rdc(8'h08, 32'h0000_0006);
    wr(8'h08, 32'h0000_0004);
    send({4'h4, 3'h0, 1'b1, 3'h5, 13'h0003});
    chk(pump_fast_current, 3'h5);
    send({4'h2, 1'b0, 4'h3, 15'h0208});
    rdc(8'h08, 32'h0000_0006);
    wr(8'h08, 32'h0000_0004);
    send({4'h2, 1'b0, 4'h3, 15'h0209});
    chk({boost_on, lock_out, whole_divide_value}, {2'h2, 15'h0209});
    tick(2);
    chk(boost_on, 1'b1);
    tick(1);
    chk(boost_on, 1'b0);
    tick(59);
    chk(lock_out, 1'b0);
    tick(1);
    chk(lock_out, 1'b1);
    phase_ok <= 1'b0;
    tick(4);
    chk(lock_out, 1'b0);
    wr(8'h00, 32'h0000_0001);
    repeat (10) @(posedge hclk);
    chk({power_state, pump_hiz, whole_divide_value},
        {SSC_PWR_SAVE, 1'b1, 15'h0209});
    print_verdict();
  end
endmodule
